// [logic/i2c_flag_params.svh]
// Constants for the two-wire status flag tracker
`ifndef I2C_FLAG_PARAMS_SVH
`define I2C_FLAG_PARAMS_SVH

// =====================================================
// Bit counting within a byte
`define CLK_CNT_W      4
`define CLK_CNT_IDLE   4'h0
`define CLK_CNT_FIRST  4'h1
`define CLK_CNT_DIR    4'h8
`define CLK_CNT_ACK    4'h9

// =====================================================
// Bus line reset levels (idle bus is high)
`define LINE_RST_LVL   2'h3
`define LINE_SCL_IDX   0
`define LINE_SDA_IDX   1
`define LINE_CNT       2

`endif

// [logic/i2c_flag_pkg.sv]
// Types shared by the two-wire status flag tracker
`default_nettype none
`include "i2c_flag_params.svh"

package i2c_flag_pkg;

   // =====================================================
   // Status flags as seen by software
   typedef struct packed {
      logic master_active_flag;
      logic arb_lost_flag;
      logic xmit_recv_flag;
      logic ack_seen_flag;
      logic start_seen_flag;
      logic stop_seen_flag;
   } status_flags_t;

   // =====================================================
   // Line sampler state
   typedef struct packed {
      logic [`LINE_CNT-1:0] meta;
      logic [`LINE_CNT-1:0] sync;
      logic [`LINE_CNT-1:0] prev;
   } line_sync_t;

   // =====================================================
   // Tracker state
   typedef struct packed {
      status_flags_t             flags;
      logic                      stop_armed;
      logic                      dir_bit;
      logic [`CLK_CNT_W-1:0]     clk_cnt;
      logic                      first_byte;
      logic                      sda_out;
      logic                      sda_oe;
   } tracker_t;

endpackage : i2c_flag_pkg
`default_nettype wire

// [logic/i2c_line_sync.sv]
// Two-flop synchroniser and edge finder for the bus lines
`timescale 1ns/1ps
`default_nettype none
`include "i2c_flag_params.svh"

module i2c_line_sync (
   // Clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   // Raw lines
   input  wire logic [`LINE_CNT-1:0]  line_i,
   // Synchronised level and edges
   output logic      [`LINE_CNT-1:0]  level_o,
   output logic      [`LINE_CNT-1:0]  rise_o,
   output logic      [`LINE_CNT-1:0]  fall_o
);
   import i2c_flag_pkg::*;

   line_sync_t q;
   line_sync_t d;

   always_comb begin
      d      = q;
      d.meta = line_i;
      d.sync = q.meta;
      d.prev = q.sync;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '{meta: `LINE_RST_LVL, sync: `LINE_RST_LVL, prev: `LINE_RST_LVL};
      end else begin
         q <= d;
      end
   end

   // =====================================================
   // Edges compare second stage against its delayed copy
   genvar i;
   generate
      for (i = 0; i < `LINE_CNT; i++) begin : g_edge
         assign level_o[i] = q.sync[i];
         assign rise_o[i]  = q.sync[i] & ~q.prev[i];
         assign fall_o[i]  = ~q.sync[i] & q.prev[i];
      end
   endgenerate

endmodule : i2c_line_sync
`default_nettype wire

// [logic/i2c_status_flag_tracker.sv]
// Direction, ack, start and stop flag tracking for one two-wire bus unit
`timescale 1ns/1ps
`default_nettype none
`include "i2c_flag_params.svh"

module i2c_status_flag_tracker (
   // Clock and reset
   input  wire logic                         sys_clk_i,
   input  wire logic                         rst_n_i,
   // Bus lines
   input  wire logic                         serial_clock_line_i,
   input  wire logic                         serial_data_line_i,
   output logic                              serial_data_line_o,
   output logic                              serial_data_line_oe_o,
   // Core controls
   input  wire logic                         unit_on_bit_i,
   input  wire logic                         leave_comm_cmd_i,
   input  wire logic                         wait_release_cmd_i,
   input  wire logic                         start_gen_i,
   input  wire logic                         arb_loss_i,
   input  wire logic                         status_read_i,
   input  wire logic                         slave_selected_i,
   input  wire logic                         shift_out_bit_i,
   // Status
   output i2c_flag_pkg::status_flags_t       status_o
);
   import i2c_flag_pkg::*;

   tracker_t q;
   tracker_t d;

   logic [`LINE_CNT-1:0] line_lvl;
   logic [`LINE_CNT-1:0] line_rise;
   logic [`LINE_CNT-1:0] line_fall;

   // =====================================================
   // Line sampling
   i2c_line_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .line_i    ({serial_data_line_i, serial_clock_line_i}),
      .level_o   (line_lvl),
      .rise_o    (line_rise),
      .fall_o    (line_fall)
   );

   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic sda_lvl;
   logic dir_clk;
   logic ninth_clk;
   logic next_first;
   logic arb_rise;

   assign scl_rise   = line_rise[`LINE_SCL_IDX];
   assign sda_lvl    = line_lvl[`LINE_SDA_IDX];
   assign start_det  = line_lvl[`LINE_SCL_IDX] & line_fall[`LINE_SDA_IDX];
   assign stop_det   = line_lvl[`LINE_SCL_IDX] & line_rise[`LINE_SDA_IDX];
   assign dir_clk    = scl_rise & (q.clk_cnt == (`CLK_CNT_DIR - `CLK_CNT_FIRST));
   assign ninth_clk  = scl_rise & (q.clk_cnt == (`CLK_CNT_ACK - `CLK_CNT_FIRST));
   assign next_first = scl_rise & (q.clk_cnt == `CLK_CNT_ACK);

   // =====================================================
   // Flag logic
   always_comb begin
      d        = q;
      arb_rise = 1'b0;

      // Clock counting within a frame
      if (start_det) begin
         d.clk_cnt    = `CLK_CNT_IDLE;
         d.first_byte = 1'b1;
      end else if (scl_rise) begin
         if (q.clk_cnt == `CLK_CNT_ACK) begin
            d.clk_cnt    = `CLK_CNT_FIRST;
            d.first_byte = 1'b0;
         end else begin
            d.clk_cnt = q.clk_cnt + `CLK_CNT_FIRST;
         end
      end
      if (dir_clk && q.first_byte) begin
         d.dir_bit = sda_lvl;
      end

      // Arbitration loss; set wins over the read clear
      if (status_read_i) begin
         d.flags.arb_lost_flag = 1'b0;
      end
      if (arb_loss_i && q.flags.master_active_flag) begin
         d.flags.arb_lost_flag = 1'b1;
      end
      // A loss counts as setting even when the flag already reads 1
      arb_rise = arb_loss_i & q.flags.master_active_flag;

      // Master status
      if (stop_det || leave_comm_cmd_i || arb_rise) begin
         d.flags.master_active_flag = 1'b0;
      end
      if (start_gen_i) begin
         d.flags.master_active_flag = 1'b1;
      end

      // Direction flag clears
      if (stop_det || leave_comm_cmd_i || wait_release_cmd_i || arb_rise) begin
         d.flags.xmit_recv_flag = 1'b0;
      end
      if (start_det && !q.flags.master_active_flag) begin
         d.flags.xmit_recv_flag = 1'b0;
      end
      // Direction decided at the first byte's ninth clock
      if (ninth_clk && q.first_byte) begin
         if (q.flags.master_active_flag) begin
            d.flags.xmit_recv_flag = ~q.dir_bit;
         end else begin
            d.flags.xmit_recv_flag = q.dir_bit & slave_selected_i;
         end
      end
      // Arbitration loss beats the ninth-clock decision
      if (arb_rise) begin
         d.flags.xmit_recv_flag = 1'b0;
      end

      // Ack flag
      if (stop_det || next_first || leave_comm_cmd_i) begin
         d.flags.ack_seen_flag = 1'b0;
      end
      if (ninth_clk && !sda_lvl) begin
         d.flags.ack_seen_flag = 1'b1;
      end

      // Start flag
      if (stop_det || (next_first && q.first_byte) || leave_comm_cmd_i) begin
         d.flags.start_seen_flag = 1'b0;
      end
      if (start_det) begin
         d.flags.start_seen_flag = 1'b1;
      end

      // Stop flag, cleared at the first address clock after a start
      if (scl_rise && q.stop_armed && q.clk_cnt == `CLK_CNT_IDLE) begin
         d.flags.stop_seen_flag = 1'b0;
         d.stop_armed           = 1'b0;
      end
      if (start_det && q.flags.stop_seen_flag) begin
         d.stop_armed = 1'b1;
      end
      if (stop_det) begin
         d.flags.stop_seen_flag = 1'b1;
         d.stop_armed           = 1'b0;
      end

      // Unit off holds every flag clear
      if (!unit_on_bit_i) begin
         d.flags      = '0;
         d.stop_armed = 1'b0;
      end

      // Data line drive follows the direction flag
      d.sda_oe  = d.flags.xmit_recv_flag;
      d.sda_out = shift_out_bit_i;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Read-only status view
   assign status_o              = q.flags;
   assign serial_data_line_o    = q.sda_out;
   assign serial_data_line_oe_o = q.sda_oe;

   // =====================================================
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence seq_first_ninth;
      ninth_clk && q.first_byte && unit_on_bit_i && !stop_det;
   endsequence

   sequence seq_release_alone;
      wait_release_cmd_i && !(ninth_clk && q.first_byte);
   endsequence

   AST_RECV_FLOATS: assert property (!q.flags.xmit_recv_flag |-> !serial_data_line_oe_o)
      else $error("data line driven in receive status");
   AST_XMIT_DRIVES: assert property (q.flags.xmit_recv_flag |->
         serial_data_line_oe_o && serial_data_line_o == $past(shift_out_bit_i))
      else $error("data line not driven with shift-out bit");
   AST_STOP_CLEARS: assert property (stop_det |=> !q.flags.xmit_recv_flag
         && !q.flags.ack_seen_flag && !q.flags.start_seen_flag && q.flags.stop_seen_flag
         || !$past(unit_on_bit_i))
      else $error("stop did not update flags");
   AST_MASTER_DIR: assert property (seq_first_ninth ##0 q.flags.master_active_flag
         && !arb_loss_i |=> q.flags.xmit_recv_flag == !$past(q.dir_bit))
      else $error("master direction flag wrong");
   AST_SLAVE_DIR: assert property (seq_first_ninth ##0 !q.flags.master_active_flag
         |=> q.flags.xmit_recv_flag == ($past(q.dir_bit) && $past(slave_selected_i)))
      else $error("slave direction flag wrong");
   AST_WAIT_RELEASE: assert property (seq_release_alone |=>
         !q.flags.xmit_recv_flag && !serial_data_line_oe_o)
      else $error("wait release left data line driven");
   AST_ACK_SET: assert property (ninth_clk && !sda_lvl && unit_on_bit_i
         |=> q.flags.ack_seen_flag)
      else $error("ack not captured at ninth clock");
   AST_ACK_NEXT: assert property (next_first && !start_det |=> !q.flags.ack_seen_flag)
      else $error("ack not cleared at next byte");
   AST_START_SET: assert property (start_det && unit_on_bit_i
         |=> q.flags.start_seen_flag [*1] ##1 q.flags.start_seen_flag || scl_rise || stop_det)
      else $error("start flag not set");
   AST_START_CLEAR: assert property (next_first && q.first_byte && !start_det
         |=> !q.flags.start_seen_flag)
      else $error("start flag not cleared after address");
   AST_STOP_HOLD: assert property (q.flags.stop_seen_flag && unit_on_bit_i
         && !(scl_rise && q.stop_armed) |=> q.flags.stop_seen_flag)
      else $error("stop flag cleared early");
   AST_ARB_LOSS: assert property (arb_loss_i && q.flags.master_active_flag && unit_on_bit_i
         |=> q.flags.arb_lost_flag && !q.flags.master_active_flag
         && !q.flags.xmit_recv_flag || $past(start_gen_i))
      else $error("arbitration loss not flagged");
   AST_UNIT_OFF: assert property (!unit_on_bit_i |=> q.flags == '0)
      else $error("flags survive unit off");

endmodule : i2c_status_flag_tracker
`default_nettype wire

// [sim/i2c_bus_partner.sv]
// Behavioural bus master that drives the clock and data lines of the two-wire bus
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_partner (
   // Clock
   input  wire logic sys_clk_i,
   // Bus lines, 1 = released to the pull-up
   output logic      scl_o,
   output logic      sda_o
);
   // Quarter of a 160 ns link clock at 20 ns per cycle
   localparam int QTR = 2;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic step(input int n, input logic c, input logic d);
      repeat (n * QTR) @(posedge sys_clk_i);
      scl_o <= c;
      sda_o <= d;
   endtask : step

   task automatic start_cond();
      step(2, 1'b0, 1'b1);
      step(2, 1'b1, 1'b1);
      step(2, 1'b1, 1'b0);
      step(2, 1'b0, 1'b0);
   endtask : start_cond

   task automatic stop_cond();
      step(2, 1'b0, 1'b0);
      step(2, 1'b1, 1'b0);
      step(2, 1'b1, 1'b1);
   endtask : stop_cond

   // Data set mid-way through the low phase, so no false start or stop
   task automatic send_bit(input logic b);
      step(1, 1'b0, b);
      step(1, 1'b1, b);
      step(2, 1'b0, b);
   endtask : send_bit

   // Eight bits MSB first, then the ninth clock with ack_n on the line
   task automatic send_byte(input logic [7:0] b, input logic ack_n);
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i]);
      end
      send_bit(ack_n);
   endtask : send_byte
endmodule : i2c_bus_partner
`default_nettype wire

// [sim/i2c_status_flag_tracker_test.sv]
// Self-checking bench for the two-wire status flag tracker
`timescale 1ns/1ps
`default_nettype none

module i2c_status_flag_tracker_test;
   import i2c_flag_pkg::*;
   logic          sys_clk_i;
   logic          rst_n_i;
   logic          unit_on;
   logic          sel;
   logic          shift_bit;
   logic [4:0]    cmd;
   logic          scl_p;
   logic          sda_p;
   logic          sda_o;
   logic          sda_oe;
   logic          sda_w;
   status_flags_t status;
   int            mismatches;
   int            n_compared;
   logic          m;
   logic          d;
   logic          s;
   logic          a;

   // Open-drain data line with pull-up
   assign sda_w = sda_p & ~(sda_oe & ~sda_o);

   i2c_bus_partner bus (.sys_clk_i(sys_clk_i), .scl_o(scl_p), .sda_o(sda_p));

   i2c_status_flag_tracker dut (
      .sys_clk_i            (sys_clk_i),
      .rst_n_i              (rst_n_i),
      .serial_clock_line_i  (scl_p),
      .serial_data_line_i   (sda_w),
      .serial_data_line_o   (sda_o),
      .serial_data_line_oe_o(sda_oe),
      .unit_on_bit_i        (unit_on),
      .leave_comm_cmd_i     (cmd[0]),
      .wait_release_cmd_i   (cmd[1]),
      .start_gen_i          (cmd[2]),
      .arb_loss_i           (cmd[3]),
      .status_read_i        (cmd[4]),
      .slave_selected_i     (sel),
      .shift_out_bit_i      (shift_bit),
      .status_o             (status)
   );

   function automatic logic exp_dir(input logic mst, input logic dir, input logic slv);
      return mst ? ~dir : (dir & slv);
   endfunction : exp_dir

   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   task automatic fail(input string what);
      mismatches++;
      $display("Error at %0t: %s", $time, what);
   endtask : fail

   // Flags and drive enable settle a few cycles after the line event
   task automatic chk(input logic [5:0] exp, input string what);
      repeat (3) @(posedge sys_clk_i);
      #1;
      n_compared++;
      if (status !== exp || sda_oe !== exp[3]) begin
         fail(what);
      end
      @(posedge sys_clk_i);
   endtask : chk

   task automatic pulse(input int b);
      @(posedge sys_clk_i);
      cmd[b] <= 1'b1;
      @(posedge sys_clk_i);
      cmd <= '0;
   endtask : pulse

   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      rst_n_i = 1'b0;
      unit_on = 1'b1;
      sel = 1'b0;
      shift_bit = 1'b0;
      cmd = '0;
      mismatches = 0;
      n_compared = 0;
      void'($urandom(32'h4469a33b));
      repeat (8) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      chk(6'h00, "reset values");
      // Slave read, wait release, data byte, stop
      sel <= 1'b1;
      shift_bit <= 1'($urandom);
      bus.start_cond();
      chk(6'h02, "start flag");
      bus.send_byte({7'($urandom), 1'b1}, 1'b0);
      chk(6'h0e, "slave read address");
      n_compared++;
      if (sda_o !== shift_bit) fail("data out value");
      pulse(1);
      chk(6'h06, "wait release");
      bus.send_byte(8'hff, 1'b1);
      chk(6'h00, "next byte clears");
      bus.stop_cond();
      chk(6'h01, "stop flag");
      $display("Test slave_read done");
      // Master write, arbitration loss, status read, leave
      pulse(2);
      bus.start_cond();
      chk(6'h23, "stop flag kept over start");
      bus.send_byte({7'($urandom), 1'b0}, 1'b0);
      chk(6'h2e, "master write address");
      pulse(3);
      chk(6'h16, "arbitration loss");
      pulse(4);
      chk(6'h06, "status read");
      pulse(0);
      chk(6'h00, "leave command");
      bus.stop_cond();
      chk(6'h01, "stop after leave");
      unit_on <= 1'b0;
      chk(6'h00, "unit off");
      unit_on <= 1'b1;
      $display("Test master_write done");
      // Random direction, role, selection and ack
      for (int i = 0; i < 8; i++) begin
         m = 1'($urandom);
         d = 1'($urandom);
         s = 1'($urandom);
         a = 1'($urandom);
         // Unit drives from the ninth rise; never pull a released line low then
         shift_bit <= a | 1'($urandom);
         sel <= s;
         if (m) pulse(2);
         bus.start_cond();
         bus.send_byte({7'($urandom), d}, a);
         chk({m, 1'b0, exp_dir(m, d, s), ~a, 2'b10}, "random address");
         pulse(0);
         bus.stop_cond();
         chk(6'h01, "random stop");
      end
      $display("Test random_bytes done");
      finish_test();
   end
endmodule : i2c_status_flag_tracker_test
`default_nettype wire
